// File: pkg/rssd_regs.svh
// Offsets, field positions, reset values and widths of the rotate/subtract/skip datapath
`ifndef RSSD_REGS_SVH
`define RSSD_REGS_SVH

`define RSSD_BUS_AW          6
`define RSSD_ADDR_W          5
`define RSSD_MEM_BASE        6'h00
`define RSSD_WORK_OFS        6'h20
`define RSSD_FLAGS_OFS       6'h21
`define RSSD_CARRY_POS       0
`define RSSD_HALF_POS        1
`define RSSD_ZERO_POS        2
`define RSSD_SIGNED_POS      3
`define RSSD_WORK_RESET      8'h00
`define RSSD_FLAGS_RESET     4'h0
`define RSSD_MEM_RESET       8'h00
`define RSSD_ALL_ONES        8'hFF
`define RSSD_UNMAPPED_READ   8'h00

`endif

// File: pkg/rssd_pkg.sv
// Types shared by the rotate/subtract/skip datapath
`include "rssd_regs.svh"

package rssd_pkg;

   typedef enum logic [3:0] {
      OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING,
      OP_BORROW_MINUS_OP,
      OP_BORROW_MINUS_TO_MEM,
      OP_DECREMENT_SKIP_ZERO,
      OP_DECREMENT_TO_WORKING_SKIP,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_INCREMENT_SKIP_ZERO,
      OP_INCREMENT_TO_WORKING_SKIP,
      OP_BIT_NONZERO_SKIP,
      OP_MINUS_OP,
      OP_MINUS_TO_MEM,
      OP_MINUS_IMM,
      OP_SWAP_NIBBLES
   } rssd_op_type;

   // Bit order follows the flag positions of the register map
   typedef struct packed {
      logic signed_range_flag;
      logic zero_flag;
      logic half_nibble_flag;
      logic carry_flag;
   } rssd_flags_type;

   typedef struct packed {
      rssd_op_type                op;
      logic [`RSSD_ADDR_W-1:0]    addr;
      logic [2:0]                 bit_sel;
      logic [7:0]                 imm;
   } rssd_instr_type;

   typedef struct packed {
      logic [7:0]     sum;
      rssd_flags_type flags;
   } rssd_addsub_type;

   function automatic logic [7:0] rssd_bit_mask(input logic [2:0] sel);
      rssd_bit_mask = 8'h01 << sel;
   endfunction : rssd_bit_mask

endpackage : rssd_pkg

// File: hdl/rssd_addsub.sv
// Eight-bit subtractor built as a plus inverted b plus carry-in, with flags
`timescale 1ns/10ps

module rssd_addsub (
   // Operands
   input  wire logic                     [7:0] a,
   input  wire logic                     [7:0] b,
   input  wire logic                           carry_in,
   // Result
   output rssd_pkg::rssd_addsub_type           res
);

   logic [7:0] b_inv;
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   assign b_inv    = ~b;
   assign full_sum = {1'b0, a} + {1'b0, b_inv} + {8'h00, carry_in};
   assign low_sum  = {1'b0, a[3:0]} + {1'b0, b_inv[3:0]} + {4'h0, carry_in};

   assign res.sum                     = full_sum[7:0];
   // One means no borrow
   assign res.flags.carry_flag        = full_sum[8];
   assign res.flags.half_nibble_flag  = low_sum[4];
   assign res.flags.zero_flag         = (full_sum[7:0] == 8'h00);
   // Like-signed a and inverted b with a result of the other sign
   assign res.flags.signed_range_flag = (a[7] == b_inv[7]) && (full_sum[7] != a[7]);

endmodule : rssd_addsub

// File: hdl/rssd_unary_unit.sv
// Single-operand byte functions: rotate, step, swap, bit set and bit test
`timescale 1ns/10ps

module rssd_unary_unit (
   // Operand
   input  wire logic [7:0] mem_byte,
   input  wire logic       carry_in,
   input  wire logic [2:0] bit_sel,
   // Results
   output logic      [7:0] rot_val,
   output logic            rot_carry,
   output logic      [7:0] dec_val,
   output logic      [7:0] inc_val,
   output logic      [7:0] swap_val,
   output logic      [7:0] setbit_val,
   output logic            bit_hit
);

   assign rot_val    = {carry_in, mem_byte[7:1]};
   assign rot_carry  = mem_byte[0];
   assign dec_val    = mem_byte - 8'h01;
   assign inc_val    = mem_byte + 8'h01;
   assign swap_val   = {mem_byte[3:0], mem_byte[7:4]};
   assign setbit_val = mem_byte | rssd_pkg::rssd_bit_mask(bit_sel);
   assign bit_hit    = |(mem_byte & rssd_pkg::rssd_bit_mask(bit_sel));

endmodule : rssd_unary_unit

// File: hdl/rssd_datapath.sv
// Execution datapath for rotate, subtract, step-and-skip, set and swap operations
//
// Function
// - Rotate memory right through carry into working
// - Borrow subtract into working, update four flags
// - Borrow subtract into memory, update four flags
// - Decrement memory in place, skip on zero
// - Decrement into working, memory kept, skip zero
// - Skip drops prefetched instruction, adds dummy cycle
// - Set byte writes all ones, flags kept
// - Set bit forces one chosen bit only
// - Increment memory in place, skip on zero
// - Increment into working, memory kept, skip zero
// - Skip when chosen memory bit is one
// - Subtract memory into working plus one carry-in
// - Subtract memory, result back into memory
// - Subtract immediate operand into working register
// - Swap memory nibbles in place, flags kept
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "rssd_regs.svh"

module rssd_datapath #(
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           rst_b,
   input  wire logic                           clk_en,
   // Instruction from the sequencer
   input  wire logic                           op_valid,
   input  wire rssd_pkg::rssd_instr_type       op_instr,
   output logic                                op_ready,
   output logic                                skip_flush,
   // Register port
   input  wire logic [`RSSD_BUS_AW-1:0]        bus_addr,
   input  wire logic [7:0]                     bus_wdata,
   input  wire logic                           bus_wr,
   input  wire logic                           bus_rd,
   output logic      [7:0]                     bus_rdata,
   // Core state
   output logic      [7:0]                     working_register,
   output rssd_pkg::rssd_flags_type            status_flags
);

   localparam logic [`RSSD_BUS_AW-1:0] BUS_MEM_TOP = `RSSD_BUS_AW'(DEPTH);

   logic [7:0]               data_mem [DEPTH];
   logic [7:0]               working_register_reg;
   rssd_pkg::rssd_flags_type flags_reg;
   logic                     dummy_reg;
   logic [7:0]               rd_data_reg;

   logic                     take;
   logic [7:0]               cur_mem;
   logic [7:0]               sub_operand;
   logic                     sub_carry_in;
   rssd_pkg::rssd_addsub_type add_res;
   logic [7:0]               rot_val;
   logic                     rot_carry;
   logic [7:0]               dec_val;
   logic [7:0]               inc_val;
   logic [7:0]               swap_val;
   logic [7:0]               setbit_val;
   logic                     bit_hit;

   logic                     mem_we;
   logic [7:0]               mem_wdata;
   logic                     work_we;
   logic [7:0]               work_wdata;
   logic                     flags_all_we;
   logic                     carry_only_we;
   logic                     skip_cond;

   logic                     bus_mem_hit;

   // During the dummy cycle the prefetched instruction is being dropped
   assign op_ready  = ~dummy_reg;
   assign take      = op_valid & op_ready & clk_en;
   assign cur_mem   = data_mem[op_instr.addr];
   assign bus_mem_hit = (bus_addr < BUS_MEM_TOP);

   assign sub_operand  = (op_instr.op == rssd_pkg::OP_MINUS_IMM) ? op_instr.imm : cur_mem;
   assign sub_carry_in = (op_instr.op == rssd_pkg::OP_BORROW_MINUS_OP ||
                          op_instr.op == rssd_pkg::OP_BORROW_MINUS_TO_MEM)
                         ? flags_reg.carry_flag : 1'b1;

   rssd_addsub u_addsub (
      .a        (working_register_reg),
      .b        (sub_operand),
      .carry_in (sub_carry_in),
      .res      (add_res)
   );

   rssd_unary_unit u_unary (
      .mem_byte   (cur_mem),
      .carry_in   (flags_reg.carry_flag),
      .bit_sel    (op_instr.bit_sel),
      .rot_val    (rot_val),
      .rot_carry  (rot_carry),
      .dec_val    (dec_val),
      .inc_val    (inc_val),
      .swap_val   (swap_val),
      .setbit_val (setbit_val),
      .bit_hit    (bit_hit)
   );

   // Per-operation destination and skip decode
   always_comb begin
      mem_we        = 1'b0;
      mem_wdata     = cur_mem;
      work_we       = 1'b0;
      work_wdata    = working_register_reg;
      flags_all_we  = 1'b0;
      carry_only_we = 1'b0;
      skip_cond     = 1'b0;
      unique case (op_instr.op)
         rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING: begin
            work_we       = 1'b1;
            work_wdata    = rot_val;
            carry_only_we = 1'b1;
         end
         rssd_pkg::OP_BORROW_MINUS_OP: begin
            work_we      = 1'b1;
            work_wdata   = add_res.sum;
            flags_all_we = 1'b1;
         end
         rssd_pkg::OP_BORROW_MINUS_TO_MEM: begin
            mem_we       = 1'b1;
            mem_wdata    = add_res.sum;
            flags_all_we = 1'b1;
         end
         rssd_pkg::OP_DECREMENT_SKIP_ZERO: begin
            mem_we    = 1'b1;
            mem_wdata = dec_val;
            skip_cond = (dec_val == 8'h00);
         end
         rssd_pkg::OP_DECREMENT_TO_WORKING_SKIP: begin
            work_we    = 1'b1;
            work_wdata = dec_val;
            skip_cond  = (dec_val == 8'h00);
         end
         rssd_pkg::OP_SET_BYTE: begin
            mem_we    = 1'b1;
            mem_wdata = `RSSD_ALL_ONES;
         end
         rssd_pkg::OP_SET_BIT: begin
            mem_we    = 1'b1;
            mem_wdata = setbit_val;
         end
         rssd_pkg::OP_INCREMENT_SKIP_ZERO: begin
            mem_we    = 1'b1;
            mem_wdata = inc_val;
            skip_cond = (inc_val == 8'h00);
         end
         rssd_pkg::OP_INCREMENT_TO_WORKING_SKIP: begin
            work_we    = 1'b1;
            work_wdata = inc_val;
            skip_cond  = (inc_val == 8'h00);
         end
         rssd_pkg::OP_BIT_NONZERO_SKIP: begin
            skip_cond = bit_hit;
         end
         rssd_pkg::OP_MINUS_OP: begin
            work_we      = 1'b1;
            work_wdata   = add_res.sum;
            flags_all_we = 1'b1;
         end
         rssd_pkg::OP_MINUS_TO_MEM: begin
            mem_we       = 1'b1;
            mem_wdata    = add_res.sum;
            flags_all_we = 1'b1;
         end
         rssd_pkg::OP_MINUS_IMM: begin
            work_we      = 1'b1;
            work_wdata   = add_res.sum;
            flags_all_we = 1'b1;
         end
         rssd_pkg::OP_SWAP_NIBBLES: begin
            mem_we    = 1'b1;
            mem_wdata = swap_val;
         end
         // Unused opcodes act as no operation
         default: begin
            mem_we = 1'b0;
         end
      endcase
   end

   // Data memory; an executing op wins over a register-port write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            data_mem[i] <= `RSSD_MEM_RESET;
         end
      end else if (clk_en) begin
         if (take && mem_we) begin
            data_mem[op_instr.addr] <= mem_wdata;
         end else if (bus_wr && bus_mem_hit) begin
            data_mem[bus_addr[`RSSD_ADDR_W-1:0]] <= bus_wdata;
         end
      end
   end

   // Working register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         working_register_reg <= `RSSD_WORK_RESET;
      end else if (clk_en) begin
         if (take && work_we) begin
            working_register_reg <= work_wdata;
         end else if (bus_wr && bus_addr == `RSSD_WORK_OFS) begin
            working_register_reg <= bus_wdata;
         end
      end
   end

   // Status flags; step, set and swap operations leave them alone
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flags_reg <= `RSSD_FLAGS_RESET;
      end else if (clk_en) begin
         if (take && flags_all_we) begin
            flags_reg <= add_res.flags;
         end else if (take && carry_only_we) begin
            flags_reg.carry_flag <= rot_carry;
         end else if (bus_wr && bus_addr == `RSSD_FLAGS_OFS) begin
            flags_reg <= bus_wdata[3:0];
         end
      end
   end

   // One dummy cycle after a skipping instruction
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dummy_reg <= 1'b0;
      end else if (clk_en) begin
         dummy_reg <= take & skip_cond;
      end
   end

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= `RSSD_UNMAPPED_READ;
      end else if (clk_en) begin
         if (bus_rd && bus_mem_hit) begin
            rd_data_reg <= data_mem[bus_addr[`RSSD_ADDR_W-1:0]];
         end else if (bus_rd && bus_addr == `RSSD_WORK_OFS) begin
            rd_data_reg <= working_register_reg;
         end else if (bus_rd && bus_addr == `RSSD_FLAGS_OFS) begin
            rd_data_reg <= {4'h0, flags_reg};
         end else begin
            rd_data_reg <= `RSSD_UNMAPPED_READ;
         end
      end
   end

   assign skip_flush       = dummy_reg;
   assign bus_rdata        = rd_data_reg;
   assign working_register = working_register_reg;
   assign status_flags     = flags_reg;

   // Checking helpers: byte at the address of the last op taken
   logic [`RSSD_ADDR_W-1:0] last_addr_q;
   logic [7:0]              mem_at_last;
   logic                    op_is_rot;
   logic                    op_is_bsub;
   logic                    op_is_bsub_mem;
   logic                    op_is_dec;
   logic                    op_is_set;
   logic                    op_is_setbit;
   logic                    op_is_inc;
   logic                    op_is_test;
   logic                    op_is_imm;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         last_addr_q <= '0;
      end else if (take) begin
         last_addr_q <= op_instr.addr;
      end
   end

   assign mem_at_last    = data_mem[last_addr_q];
   assign op_is_rot      = take && op_instr.op == rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING;
   assign op_is_bsub     = take && op_instr.op == rssd_pkg::OP_BORROW_MINUS_OP;
   assign op_is_bsub_mem = take && op_instr.op == rssd_pkg::OP_BORROW_MINUS_TO_MEM;
   assign op_is_dec      = take && op_instr.op == rssd_pkg::OP_DECREMENT_SKIP_ZERO;
   assign op_is_set      = take && op_instr.op == rssd_pkg::OP_SET_BYTE;
   assign op_is_setbit   = take && op_instr.op == rssd_pkg::OP_SET_BIT;
   assign op_is_inc      = take && op_instr.op == rssd_pkg::OP_INCREMENT_SKIP_ZERO;
   assign op_is_test     = take && op_instr.op == rssd_pkg::OP_BIT_NONZERO_SKIP;
   assign op_is_imm      = take && op_instr.op == rssd_pkg::OP_MINUS_IMM;

   AST_ROTATE_RESULT: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_rot |=> working_register_reg == $past(rot_val)
                    && flags_reg.carry_flag == $past(rot_carry))
      else $error("rotate through carry gave wrong working value or carry");

   AST_BORROW_WORKING: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_bsub |=> working_register_reg == $past(add_res.sum) && flags_reg == $past(add_res.flags))
      else $error("borrow subtract to working wrong result or flags");

   AST_BORROW_MEMORY: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_bsub_mem |=> mem_at_last == $past(add_res.sum) && $stable(working_register_reg))
      else $error("borrow subtract to memory wrong result");

   AST_DECREMENT_SKIP: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_dec |=> mem_at_last == $past(dec_val) && $stable(flags_reg)
                    && skip_flush == ($past(dec_val) == 8'h00))
      else $error("decrement skip wrong memory, flags or skip");

   AST_SKIP_DUMMY: assert property (@(posedge mclk) disable iff (!rst_b)
      (take && skip_cond) |=> !op_ready && skip_flush ##1 (!clk_en || op_ready))
      else $error("skip did not insert exactly one dummy cycle");

   AST_NO_SKIP_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_b)
      (take && !skip_cond) |=> op_ready && !skip_flush)
      else $error("non skipping op stalled the sequencer");

   AST_SET_BYTE: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_set |=> mem_at_last == `RSSD_ALL_ONES && $stable(flags_reg))
      else $error("set byte did not write all ones");

   AST_SET_BIT: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_setbit |=> mem_at_last == $past(setbit_val) && $stable(flags_reg))
      else $error("set bit changed more than the chosen bit");

   AST_INCREMENT_SKIP: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_inc |=> mem_at_last == $past(inc_val)
                    && skip_flush == ($past(inc_val) == 8'h00))
      else $error("increment skip wrong memory or skip");

   AST_BIT_TEST_SKIP: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_test |=> skip_flush == $past(bit_hit) && $stable(flags_reg))
      else $error("bit test skip decision wrong");

   AST_IMMEDIATE_SUB: assert property (@(posedge mclk) disable iff (!rst_b)
      op_is_imm |=> working_register_reg == $past(add_res.sum)
                    && flags_reg.carry_flag == $past(add_res.flags.carry_flag))
      else $error("immediate subtract wrong result");

endmodule : rssd_datapath

// File: bench/rssd_seq_model.sv
// Behavioural fetch/decode sequencer that feeds ops and drops prefetched ones on a skip
`timescale 1ns/10ps

module rssd_seq_model (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire logic                clk_en,
   // Datapath handshake
   input  wire logic                op_ready,
   input  wire logic                skip_flush,
   output logic                     op_valid,
   output rssd_pkg::rssd_instr_type op_instr,
   // Observation
   output int                       flush_cnt
);
   rssd_pkg::rssd_instr_type q[$];

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         op_valid  <= 1'b0;
         op_instr  <= '0;
         flush_cnt <= 0;
      end else if (clk_en) begin
         if (skip_flush) begin
            // Prefetched op is thrown away, the dummy cycle replaces it
            if (q.size() != 0)
               q.pop_front();
            flush_cnt <= flush_cnt + 1;
         end else if (op_valid && op_ready) begin
            q.pop_front();
         end
         op_valid <= (q.size() != 0);
         // Idle bus shows the inverse so a stale op can never pass for a fresh one
         op_instr <= (q.size() != 0) ? q[0] : ~op_instr;
      end
   end
endmodule : rssd_seq_model

// File: bench/rssd_datapath_tb.sv
// Self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/10ps

`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module rssd_datapath_tb;
   logic                     mclk;
   logic                     rst_b;
   logic                     clk_en;
   logic                     op_valid;
   rssd_pkg::rssd_instr_type op_instr;
   logic                     op_ready;
   logic                     skip_flush;
   logic [5:0]               bus_addr;
   logic [7:0]               bus_wdata;
   logic                     bus_wr;
   logic                     bus_rd;
   logic [7:0]               bus_rdata;
   logic [7:0]               working_register;
   rssd_pkg::rssd_flags_type status_flags;
   int                       flush_cnt;
   int                       error_cnt;
   int                       comparisons;
   int                       flush_exp;
   logic [7:0]               mem_exp [32];
   logic [7:0]               work_exp;
   rssd_pkg::rssd_flags_type flags_exp;

   rssd_datapath rssd_datapath_i (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid), .op_instr(op_instr),
      .op_ready(op_ready), .skip_flush(skip_flush), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .working_register(working_register), .status_flags(status_flags));

   rssd_seq_model rssd_seq_model_i (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .op_ready(op_ready),
      .skip_flush(skip_flush), .op_valid(op_valid), .op_instr(op_instr),
      .flush_cnt(flush_cnt));

   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      if (a < 6'h20)
         mem_exp[a[4:0]] = d;
      if (a == 6'h20)
         work_exp = d;
      if (a == 6'h21)
         flags_exp = d[3:0];
      @(posedge mclk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd   <= 1'b0;
      #1;
      `CHK("bus read", bus_rdata, e)
   endtask : rd

   // Subtract as a plus inverted b plus carry: {result, signed, zero, half, carry}
   function automatic logic [11:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
      sub_ref = {s[7:0], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
   endfunction : sub_ref

   // Opcode numbers follow the enum order; vic queues a byte set to 1E behind the op
   task automatic do_op(input logic [3:0] oc, input logic [4:0] a, input logic [2:0] bs,
                        input logic [7:0] imm, input logic vic);
      logic [7:0]  m;
      logic [11:0] r;
      logic        sk;
      int          n;
      m = mem_exp[a];
      n = 0;
      case (oc)
         4'h0: begin
            work_exp = {flags_exp.carry_flag, m[7:1]};
            flags_exp.carry_flag = m[0];
         end
         4'h1, 4'h2, 4'hA, 4'hB, 4'hC: begin
            r = sub_ref(work_exp, (oc == 4'hC) ? imm : m,
                        (oc < 4'h3) ? flags_exp.carry_flag : 1'b1);
            flags_exp = r[3:0];
            if (oc == 4'h2 || oc == 4'hB)
               mem_exp[a] = r[11:4];
            else
               work_exp = r[11:4];
         end
         4'h3: mem_exp[a] = m - 8'h01;
         4'h4: work_exp = m - 8'h01;
         4'h5: mem_exp[a] = 8'hFF;
         4'h6: mem_exp[a] = m | (8'h01 << bs);
         4'h7: mem_exp[a] = m + 8'h01;
         4'h8: work_exp = m + 8'h01;
         4'hD: mem_exp[a] = {m[3:0], m[7:4]};
         default: ;
      endcase
      sk = ((oc == 4'h3 || oc == 4'h4) && m == 8'h01) || (oc == 4'h9 && m[bs])
           || ((oc == 4'h7 || oc == 4'h8) && m == 8'hFF);
      rssd_seq_model_i.q.push_back({rssd_pkg::rssd_op_type'(oc), a, bs, imm});
      if (vic)
         rssd_seq_model_i.q.push_back({4'h5, 5'h1E, 3'h0, 8'h00});
      if (vic && !sk)
         mem_exp[30] = 8'hFF;
      if (sk)
         flush_exp++;
      while (rssd_seq_model_i.q.size() != 0 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      // One edge more lets the flush of a skip land
      @(posedge mclk);
      #1;
      `CHK("working", working_register, work_exp)
      `CHK("flags", status_flags, flags_exp)
      `CHK("skips", flush_cnt, flush_exp)
      rd({1'b0, a}, mem_exp[a]);
      rd(6'h1E, mem_exp[30]);
   endtask : do_op

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // A full run needs about 330 cycles
   initial begin
      repeat (6000) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      bus_addr = 6'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      flush_exp = 0;
      work_exp = 8'h00;
      flags_exp = 4'h0;
      foreach (mem_exp[i]) mem_exp[i] = 8'h00;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      rd(6'h20, 8'h00);
      rd(6'h21, 8'h00);
      rd(6'h05, 8'h00);
      wr(6'h3F, 8'hA5);
      rd(6'h3F, 8'h00);
      wr(6'h21, 8'hFE);
      rd(6'h21, 8'h0E);
      wr(6'h01, 8'h81);
      do_op(4'h0, 5'h01, 3'h0, 8'h00, 1'b0);
      wr(6'h01, 8'h02);
      do_op(4'h0, 5'h01, 3'h0, 8'h00, 1'b0);
      wr(6'h02, 8'h01);
      do_op(4'h1, 5'h02, 3'h0, 8'h00, 1'b0);
      wr(6'h03, 8'h7F);
      do_op(4'h2, 5'h03, 3'h0, 8'h00, 1'b0);
      do_op(4'hA, 5'h02, 3'h0, 8'h00, 1'b0);
      wr(6'h04, 8'h80);
      do_op(4'hB, 5'h04, 3'h0, 8'h00, 1'b0);
      do_op(4'hC, 5'h00, 3'h0, 8'hFE, 1'b0);
      do_op(4'hC, 5'h00, 3'h0, 8'h00, 1'b0);
      wr(6'h05, 8'h01);
      do_op(4'h3, 5'h05, 3'h0, 8'h00, 1'b1);
      do_op(4'h3, 5'h05, 3'h0, 8'h00, 1'b1);
      wr(6'h06, 8'h01);
      do_op(4'h4, 5'h06, 3'h0, 8'h00, 1'b0);
      wr(6'h06, 8'h00);
      do_op(4'h4, 5'h06, 3'h0, 8'h00, 1'b0);
      wr(6'h1E, 8'h00);
      wr(6'h07, 8'hFF);
      do_op(4'h7, 5'h07, 3'h0, 8'h00, 1'b1);
      do_op(4'h7, 5'h07, 3'h0, 8'h00, 1'b0);
      do_op(4'h8, 5'h07, 3'h0, 8'h00, 1'b0);
      wr(6'h07, 8'hFF);
      do_op(4'h8, 5'h07, 3'h0, 8'h00, 1'b0);
      wr(6'h08, 8'h10);
      for (int i = 0; i < 8; i++) begin
         do_op(4'h9, 5'h08, 3'(i), 8'h00, 1'b0);
      end
      do_op(4'h5, 5'h09, 3'h0, 8'h00, 1'b0);
      for (int i = 0; i < 8; i++) begin
         do_op(4'h6, 5'h0A, 3'(i), 8'h00, 1'b0);
      end
      wr(6'h0B, 8'h1E);
      do_op(4'hD, 5'h0B, 3'h0, 8'h00, 1'b0);
      do_op(4'hE, 5'h0B, 3'h0, 8'h00, 1'b0);
      // Low enable must stretch the dummy cycle and refuse a bus write
      wr(6'h0C, 8'h01);
      mem_exp[12] = 8'h00;
      rssd_seq_model_i.q.push_back({4'h3, 5'h0C, 3'h0, 8'h00});
      #1;
      while (!op_valid) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      clk_en <= 1'b0;
      wr(6'h0D, 8'h55);
      mem_exp[13] = 8'h00;
      #1;
      `CHK("frozen ready", op_ready, 1'b0)
      `CHK("frozen flush", skip_flush, 1'b1)
      `CHK("frozen skips", flush_cnt, flush_exp)
      @(posedge mclk);
      clk_en <= 1'b1;
      flush_exp++;
      @(posedge mclk);
      #1;
      `CHK("ready after dummy", op_ready, 1'b1)
      `CHK("flush after dummy", skip_flush, 1'b0)
      `CHK("skips after dummy", flush_cnt, flush_exp)
      rd(6'h0C, 8'h00);
      rd(6'h0D, 8'h00);
      // Reset in mid-run clears working, flags and memory
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK("reset working", working_register, 8'h00)
      `CHK("reset flags", status_flags, 4'h0)
      `CHK("reset ready", op_ready, 1'b1)
      @(posedge mclk);
      rst_b <= 1'b1;
      rd(6'h0B, 8'h00);
      rd(6'h21, 8'h00);
      report_and_stop();
   end
endmodule : rssd_datapath_tb
